// file: src/wdrcr_pkg.sv
// Purpose: Shared constants for the watchdog reload, count and load registers.
// Assumes: Byte-wide register port with 16-bit byte addresses, core clock of 100 MHz.
// Notes:   All offsets, field positions, reset values and timing counts live here.

package wdrcr_pkg;

   // ==========================================================================
   // Clock and tick timing
   // ==========================================================================
   localparam int CLK_PERIOD_PS   = 10000;
   localparam int TICK_SLOW_NS    = 1000000;   // 1 ms decrement unit.
   localparam int TICK_FAST_NS    = 1000;      // 1 us decrement unit.
   localparam int TICK_SLOW_CYC   = (TICK_SLOW_NS * 1000) / CLK_PERIOD_PS;
   localparam int TICK_FAST_CYC   = (TICK_FAST_NS * 1000) / CLK_PERIOD_PS;
   localparam int KICK_SYNC_STAGES = 3;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam logic [15:0] CTL_LO_ADDR = 16'h3000;
   localparam logic [15:0] CTL_HI_ADDR = 16'h3001;
   localparam logic [15:0] KICK_ADDR   = 16'h3002;
   localparam logic [15:0] COUNT_ADDR  = 16'h3004;
   localparam logic [15:0] LOAD_ADDR   = 16'h3008;

   // ==========================================================================
   // Control register fields and reset values
   // ==========================================================================
   localparam int EN_BIT    = 0;
   localparam int STS_BIT   = 1;
   localparam int SIM_BIT   = 2;
   localparam int UNITS_BIT = 3;

   localparam logic [31:0] COUNT_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] LOAD_RST  = 32'hFFFF_FFFF;
   localparam logic [7:0]  KICK_READ = 8'h00;

endpackage

// file: src/wdrcr_tick_gen.sv
// Purpose: Unit tick generator for the watchdog counter, slow or fast unit.
// Assumes: Synchronous active-low reset; clk_en freezes all state.
// Notes:   The prescaler restarts whenever the watchdog stops or the unit changes.

`timescale 1ns/1ps

module wdrcr_tick_gen #(
   parameter int SLOW_CYC = wdrcr_pkg::TICK_SLOW_CYC,
   parameter int FAST_CYC = wdrcr_pkg::TICK_FAST_CYC
) (
   input  wire logic core_clk,     // Core clock.
   input  wire logic reset_n,      // Synchronous reset, active low.
   input  wire logic clk_en,       // Freezes all state while low.
   input  wire logic run,          // Watchdog enabled.
   input  wire logic fast_unit,    // High selects the 1 us unit.
   output logic      tick          // One-cycle unit pulse.
);
   import wdrcr_pkg::*;

   // The prescaler must hold the longer of the two periods, whichever one that is.
   localparam int MAX_CYC = (SLOW_CYC > FAST_CYC) ? SLOW_CYC : FAST_CYC;
   localparam int CW      = $clog2(MAX_CYC + 1);
   localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_CYC - 1);
   localparam logic [CW-1:0] FAST_LAST = CW'(FAST_CYC - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          unit;
      logic          tick;
   } wdrcr_tick_state_t;

   wdrcr_tick_state_t s_r;
   wdrcr_tick_state_t s_nxt;

   always_comb begin
      logic [CW-1:0] last;
      last = fast_unit ? FAST_LAST : SLOW_LAST;
      s_nxt      = s_r;
      s_nxt.unit = fast_unit;
      s_nxt.tick = 1'b0;
      // Stopping the prescaler is the gated-clock state of the watchdog.
      if (!run || (s_r.unit != fast_unit)) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt >= last) begin
         s_nxt.cnt  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_r <= '0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

endmodule // wdrcr_tick_gen

// file: src/wdrcr_watchdog.sv
// Purpose: Watchdog restart strobe, count snapshot, load and control registers.
// Assumes: Byte register port; one read or write strobe per cycle; 100 MHz clock.
// Notes:   Read data returns one cycle after the read strobe, with rvalid.

`timescale 1ns/1ps

// Contract
// - Enabled restart strobe write of any value reloads counter from load value.
// - Restart strobe write while disabled changes nothing.
// - Restart strobe register always reads zero; bits 7:1 reserved zero.
// - Restart reload takes effect after a few cycles of synchronisation delay.
// - Counter value readable as 32-bit read-only register, all ones after reset.
// - Lowest-byte read captures whole count; upper bytes read the capture.
// - Count snapshot bytes sit at offsets 4 through 7, low byte first.
// - Writing the load register also reloads the running counter.
// - Load register 32-bit read-write, resets all ones, offsets 8 through B.
// - Underflow past zero raises system reset request and sets expiry flag.
// - Enable bit 0 starts watchdog; clearing it stops and gates counting.
// - Units bit 0 selects 1 ms ticks, 1 selects 1 us ticks.
// - While expiry flag set, block all writes except the flag-clearing write.
module wdrcr_watchdog #(
   parameter int SLOW_CYC = wdrcr_pkg::TICK_SLOW_CYC   // Cycles per 1 ms unit.
) (
   input  wire logic        core_clk,       // Core clock, 100 MHz.
   input  wire logic        reset_n,        // Synchronous reset, active low.
   input  wire logic        clk_en,         // Freezes all state while low.
   input  wire logic [15:0] reg_addr,       // Register byte address.
   input  wire logic        reg_wr,         // Write strobe, one cycle.
   input  wire logic        reg_rd,         // Read strobe, one cycle.
   input  wire logic [7:0]  reg_wdata,      // Write data byte.
   output logic      [7:0]  reg_rdata,      // Read data byte.
   output logic             reg_rvalid,     // Read data valid pulse.
   output logic             wdt_reset_req,  // System reset request pulse.
   output logic             wdt_expired,    // Expiry flag level.
   output logic             wdt_running     // Enable bit level.
);
   import wdrcr_pkg::*;

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic                        en;
      logic                        sim;
      logic                        units;
      logic                        sts;
      logic [KICK_SYNC_STAGES-1:0] kick_pipe;
      logic [31:0]                 count;
      logic [31:0]                 load;
      logic [31:0]                 snap;
      logic [7:0]                  rdata;
      logic                        rvalid;
      logic                        rst_pulse;
   } wdrcr_state_t;

   wdrcr_state_t s_r;
   wdrcr_state_t s_nxt;
   logic         tick;

   function automatic logic in_word(input logic [15:0] a, input logic [15:0] base);
      in_word = (a[15:2] == base[15:2]);
   endfunction

   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
      byte_of = w[{i, 3'b000} +: 8];
   endfunction

   wdrcr_tick_gen #(
      .SLOW_CYC (SLOW_CYC),
      .FAST_CYC (TICK_FAST_CYC)
   ) u_tick (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .run       (s_r.en),
      .fast_unit (s_r.units),
      .tick      (tick)
   );

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   logic        wr_ok;
   logic        ctl_wr;
   logic        kick_acc;
   logic        load_wr;
   logic        kick_due;
   logic [31:0] load_new;

   always_comb begin
      // The clearing write is the only one let through while expiry is pending.
      wr_ok    = reg_wr && (!s_r.sts || ((reg_addr == CTL_LO_ADDR)
                                         && reg_wdata[STS_BIT]));
      ctl_wr   = wr_ok && (reg_addr == CTL_LO_ADDR);
      kick_acc = wr_ok && (reg_addr == KICK_ADDR) && s_r.en;
      load_wr  = wr_ok && in_word(reg_addr, LOAD_ADDR);
      kick_due = s_r.kick_pipe[KICK_SYNC_STAGES-1] && s_r.en;
      load_new = s_r.load;
      load_new[{reg_addr[1:0], 3'b000} +: 8] = reg_wdata;

      s_nxt           = s_r;
      s_nxt.rvalid    = 1'b0;
      s_nxt.rst_pulse = 1'b0;
      // A short delay line stands in for the crossing into the counter domain.
      s_nxt.kick_pipe = {s_r.kick_pipe[KICK_SYNC_STAGES-2:0], kick_acc};

      if (ctl_wr) begin
         s_nxt.en    = reg_wdata[EN_BIT];
         s_nxt.sim   = reg_wdata[SIM_BIT];
         s_nxt.units = reg_wdata[UNITS_BIT];
         if (reg_wdata[STS_BIT]) begin
            s_nxt.sts = 1'b0;
         end
      end

      // Counter updates come after the clear so an underflow in the same cycle wins.
      if (load_wr) begin
         s_nxt.load  = load_new;
         s_nxt.count = load_new;
      end else if (kick_due) begin
         s_nxt.count = s_r.load;
      end else if (s_r.en && tick) begin
         if (s_r.count == 32'h0000_0000) begin
            s_nxt.sts       = 1'b1;
            s_nxt.rst_pulse = 1'b1;
            s_nxt.count     = s_r.load;
         end else begin
            s_nxt.count = s_r.count - 32'h0000_0001;
         end
      end

      if (reg_rd) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = 8'h00;
         if (reg_addr == CTL_LO_ADDR) begin
            s_nxt.rdata = {4'h0, s_r.units, s_r.sim, s_r.sts, s_r.en};
         end else if (reg_addr == KICK_ADDR) begin
            s_nxt.rdata = KICK_READ;
         end else if (in_word(reg_addr, COUNT_ADDR)) begin
            if (reg_addr[1:0] == 2'b00) begin
               s_nxt.snap  = s_r.count;
               s_nxt.rdata = s_r.count[7:0];
            end else begin
               s_nxt.rdata = byte_of(s_r.snap, reg_addr[1:0]);
            end
         end else if (in_word(reg_addr, LOAD_ADDR)) begin
            s_nxt.rdata = byte_of(s_r.load, reg_addr[1:0]);
         end
      end
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_r           <= '0;
         s_r.count     <= COUNT_RST;
         s_r.load      <= LOAD_RST;
         s_r.snap      <= COUNT_RST;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata     = s_r.rdata;
   assign reg_rvalid    = s_r.rvalid;
   assign wdt_reset_req = s_r.rst_pulse;
   assign wdt_expired   = s_r.sts;
   assign wdt_running   = s_r.en;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_kick_reload_value: assert property (
      (clk_en && kick_due && !load_wr) |=> (s_r.count == $past(s_r.load)))
      else $error("Restart strobe did not reload the counter.");

   a_kick_disabled_ignored: assert property (
      (clk_en && reg_wr && (reg_addr == KICK_ADDR) && !s_r.en)
      |=> (s_r.kick_pipe[0] == 1'b0))
      else $error("Restart strobe acted while disabled.");

   a_kick_read_zero: assert property (
      (clk_en && reg_rd && (reg_addr == KICK_ADDR))
      |=> (reg_rvalid && (reg_rdata == 8'h00)))
      else $error("Restart strobe register read non-zero.");

   a_kick_sync_delay: assert property (
      (clk_en && kick_acc ##1 clk_en [*2]) |=> s_r.kick_pipe[2])
      else $error("Restart reload did not arrive after the sync delay.");

   a_snap_capture_low: assert property (
      (clk_en && reg_rd && (reg_addr == COUNT_ADDR))
      |=> ((s_r.snap == $past(s_r.count)) && (reg_rdata == s_r.snap[7:0])))
      else $error("Low byte read did not capture the count.");

   a_load_write_reload: assert property (
      (clk_en && load_wr && (reg_addr == LOAD_ADDR))
      |=> ((s_r.count[7:0] == $past(reg_wdata)) && (s_r.load == s_r.count)))
      else $error("Load write did not reload the counter.");

   a_underflow_flags: assert property (
      (clk_en && s_r.en && tick && (s_r.count == 32'h0) && !load_wr && !kick_due)
      |=> (wdt_expired && wdt_reset_req) ##1 (!wdt_reset_req || !$past(clk_en)))
      else $error("Underflow did not raise reset and expiry.");

   a_write_blocked_sts: assert property (
      (clk_en && s_r.sts && reg_wr && !((reg_addr == CTL_LO_ADDR) && reg_wdata[STS_BIT]))
      |=> ($stable(s_r.load) && $stable(s_r.en) && $stable(s_r.units)))
      else $error("Write passed while expiry was pending.");

   a_hold_disabled: assert property (
      (clk_en && !s_r.en && !load_wr) |=> $stable(s_r.count))
      else $error("Counter moved while disabled.");

   a_decrement_one: assert property (
      (clk_en && s_r.en && tick && (s_r.count != 32'h0) && !load_wr && !kick_due)
      |=> (s_r.count == $past(s_r.count) - 32'h1))
      else $error("Counter did not decrement by one.");

   c_kick_reload:   cover property (kick_acc ##[1:10] kick_due);
   c_underflow:     cover property (wdt_reset_req);
   c_sts_cleared:   cover property (wdt_expired ##1 !wdt_expired);
   c_snap_then_hi:  cover property ((reg_rd && reg_addr == COUNT_ADDR)
                                    ##[1:5] (reg_rd && reg_addr == 16'h3007));

endmodule // wdrcr_watchdog

// file: verif/wdrcr_testbench.sv
// Purpose: Self-checking bench for the watchdog restart, count and load registers.
// Assumes: Short 1 ms unit through SLOW_CYC; 1 us unit is 100 core cycles.
// Notes:   Inputs change at the falling edge; read data is sampled one edge later.

`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
   import wdrcr_pkg::*;

   localparam int SLOW = 20;

   logic        core_clk;
   logic        reset_n;
   logic        clk_en;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic        wdt_reset_req;
   logic        wdt_expired;
   logic        wdt_running;
   int          errors;
   int          checked;
   int          cyc;

   wdrcr_watchdog #(.SLOW_CYC(SLOW)) i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .wdt_reset_req(wdt_reset_req),
      .wdt_expired(wdt_expired), .wdt_running(wdt_running)
   );

   // ==========================================================================
   // Clock, timeout and closing report
   // ==========================================================================
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   task automatic stop_test();
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // The whole run needs under a thousand cycles, so this ceiling only catches a hang.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         $display("mismatch timeout expected end seen hang");
         stop_test();
      end
   end

   // ==========================================================================
   // Register port tasks
   // ==========================================================================
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      // One idle edge keeps back-to-back calls from touching the strobe twice at once.
      @(negedge core_clk);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string nm);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      `CHK(nm, e, reg_rdata)
      @(negedge core_clk);
   endtask

   task automatic wr_load(input logic [31:0] v);
      for (int i = 0; i < 4; i++) wr(LOAD_ADDR + 16'(i), v[8*i +: 8]);
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rd_chk(COUNT_ADDR + 16'(i), COUNT_RST[8*i +: 8], "count reset");
         rd_chk(LOAD_ADDR + 16'(i), LOAD_RST[8*i +: 8], "load reset");
      end
      rd_chk(KICK_ADDR, KICK_READ, "restart read");
      rd_chk(16'h300C, 8'h00, "unmapped read");
      `CHK("running", 1'b0, wdt_running)
   endtask

   task automatic t_fast_kick();
      wr_load(32'h0000_0005);
      rd_chk(COUNT_ADDR, 8'h05, "load reloads count");
      wr(KICK_ADDR, 8'hFF);
      wait_cyc(6);
      rd_chk(COUNT_ADDR, 8'h05, "restart while off");
      wr(CTL_LO_ADDR, 8'h09);
      `CHK("running on", 1'b1, wdt_running)
      wait_cyc(50);
      rd_chk(COUNT_ADDR, 8'h05, "before first tick");
      wait_cyc(100);
      rd_chk(COUNT_ADDR, 8'h04, "first fast tick");
      wait_cyc(100);
      rd_chk(COUNT_ADDR, 8'h03, "second fast tick");
      wr(KICK_ADDR, 8'hA5);
      rd_chk(COUNT_ADDR, 8'h03, "restart delayed");
      wait_cyc(4);
      rd_chk(COUNT_ADDR, 8'h05, "restart reload");
      rd_chk(KICK_ADDR, 8'h00, "restart reads zero");
      wr(CTL_LO_ADDR, 8'h08);
      wait_cyc(150);
      rd_chk(COUNT_ADDR, 8'h05, "hold while off");
   endtask

   task automatic t_snapshot();
      wr_load(32'hA1B2_C301);
      wr(CTL_LO_ADDR, 8'h09);
      wait_cyc(150);
      rd_chk(COUNT_ADDR, 8'h00, "live low byte");
      wait_cyc(100);
      rd_chk(COUNT_ADDR + 16'h1, 8'hC3, "snapshot byte 1");
      rd_chk(COUNT_ADDR + 16'h2, 8'hB2, "snapshot byte 2");
      rd_chk(COUNT_ADDR + 16'h3, 8'hA1, "snapshot byte 3");
      rd_chk(COUNT_ADDR, 8'hFF, "new low byte");
      rd_chk(COUNT_ADDR + 16'h1, 8'hC2, "new byte 1");
      wr(CTL_LO_ADDR, 8'h00);
   endtask

   task automatic t_expiry();
      int n;
      n = 0;
      wr_load(32'h0000_0002);
      wr(CTL_LO_ADDR, 8'h01);
      while (wdt_reset_req !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      // Three slow ticks from a count of two, plus the prescaler start cycle.
      `CHK("underflow time", 1'b1, (n >= 3 * SLOW - 5 && n <= 3 * SLOW + 10))
      `CHK("expired set", 1'b1, wdt_expired)
      @(negedge core_clk);
      `CHK("reset pulse", 1'b0, wdt_reset_req)
      rd_chk(COUNT_ADDR, 8'h02, "underflow reload");
      wr(CTL_LO_ADDR, 8'h00);
      `CHK("write blocked", 1'b1, wdt_running)
      rd_chk(LOAD_ADDR, 8'h02, "load unchanged");
      wr(CTL_LO_ADDR, 8'h02);
      `CHK("expired cleared", 1'b0, wdt_expired)
      `CHK("enable cleared", 1'b0, wdt_running)
      wr(LOAD_ADDR, 8'h07);
      rd_chk(LOAD_ADDR, 8'h07, "write after clear");
   endtask

   task automatic t_freeze();
      clk_en   = 1'b0;
      reg_addr = COUNT_ADDR;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      `CHK("frozen read", 1'b0, reg_rvalid)
      `CHK("frozen rdata", 8'h07, reg_rdata)
      @(negedge core_clk);
      clk_en   = 1'b1;
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      errors    = 0;
      checked   = 0;
      cyc       = 0;
      reset_n   = 1'b0;
      clk_en    = 1'b1;
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
      wait_cyc(8);
      reset_n   = 1'b1;
      wait_cyc(1);
      t_reset();
      t_fast_kick();
      t_snapshot();
      t_expiry();
      t_freeze();
      stop_test();
   end

endmodule // testbench
